// *** bench/tb_dual_temp_result_alarm_logic.sv ***
// self-checking bench for the temperature monitor back end
`timescale 1ns/10ps
module tb_dual_temp_result_alarm_logic;
  import tm_pkg::*;
  logic mclk;
  logic sys_rst;
  logic scl;
  logic sda_h;
  logic sda_oe;
  logic alm_oe;
  logic ot_oe;
  logic meas_req;
  logic meas_remote;
  tm_adc_s adc;
  logic [11:0] loc_raw;
  logic [11:0] rem_raw;
  logic f_open;
  logic f_short;
  logic dith;
  logic [1:0] tog;
  logic [2:0] lat;
  int rem_done;
  int n;
  int bad_count;
  int checks_done;
  wire logic sda;
  // open drain with pull-up
  assign sda = sda_h & ~sda_oe;
  tm_top #(.PERIOD_CYC(20)) u_tm_top (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .scl_i(scl),
    .sda_i(sda),
    .sda_o(),
    .sda_oe(sda_oe),
    .alarm_pin_n_o(),
    .alarm_pin_n_oe(alm_oe),
    .overtemp_comparator_pin_n_o(),
    .overtemp_comparator_pin_n_oe(ot_oe),
    .meas_req(meas_req),
    .meas_remote(meas_remote),
    .adc(adc)
  );
  tm_host u_host (.scl(scl), .sda_h(sda_h), .sda(sda));
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  // ----------------------------------------------------------------
  // converter stand-in: varying latency, scrambled data off the answer
  // ----------------------------------------------------------------
  always @(posedge mclk) begin
    adc.ack <= 1'b0;
    adc.raw <= ~adc.raw;
    if (meas_req) begin
      lat <= {rem_done[1:0], 1'b1};
    end else if (lat != 3'd0) begin
      lat <= lat - 3'd1;
      if (lat == 3'd1) begin
        adc.ack <= 1'b1;
        adc.raw <= (meas_remote ? rem_raw : loc_raw)
                   + {9'h000, dith & tog[meas_remote], 2'b00};
        adc.open <= meas_remote & f_open;
        adc.shorted <= meas_remote & f_short;
        tog[meas_remote] <= ~tog[meas_remote];
        rem_done <= rem_done + (meas_remote ? 1 : 0);
      end
    end
  end
  // ----------------------------------------------------------------
  // compare, access and wait tasks
  // ----------------------------------------------------------------
  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cmp1(input logic got, input logic exp);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic give_verdict();
    $display("checks=%0d mismatches=%0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic acc(input logic [7:0] a, input logic w,
                     input logic [7:0] d);
    logic [7:0] q;
    logic nak;
    u_host.access(a, w, d, q, nak);
    cmp1(nak, 1'b0);
    if (!w) begin
      cmp8(q, d);
    end
  endtask
  task automatic wait_rem(input int k);
    int goal;
    goal = rem_done + k;
    for (int i = 0; i < 20000 && rem_done < goal; i++) begin
      @(posedge mclk);
    end
    if (rem_done < goal) begin
      bad_count++;
      give_verdict();
    end
    repeat (6) @(posedge mclk);
  endtask
  // quarter-degree inputs, faults, then expected pin enables
  task automatic step(input logic [11:0] l, input logic [11:0] r,
                      input logic op, input logic sh, input logic a,
                      input logic o);
    @(posedge mclk);
    loc_raw <= l;
    rem_raw <= r;
    f_open <= op;
    f_short <= sh;
    wait_rem(2);
    cmp1(alm_oe, a);
    cmp1(ot_oe, o);
  endtask
  initial begin
    sys_rst = 1'b1;
    adc = '0;
    lat = 3'd0;
    tog = 2'b00;
    rem_done = 0;
    bad_count = 0;
    checks_done = 0;
    loc_raw = 12'h064;
    rem_raw = 12'h0cb;
    f_open = 1'b0;
    f_short = 1'b0;
    dith = 1'b0;
    repeat (12) @(posedge mclk);
    sys_rst <= 1'b0;
    acc(8'h03, 1'b0, 8'h00);
    acc(8'h04, 1'b0, 8'h08);
    acc(8'h21, 1'b0, 8'h0a);
    acc(8'h3f, 1'b0, 8'h00);
    acc(8'h30, 1'b1, 8'h50);
    acc(8'h30, 1'b0, 8'h50);
    step(12'h064, 12'h0cb, 1'b0, 1'b0, 1'b0, 1'b0);
    acc(8'h00, 1'b0, 8'h19);
    acc(8'h10, 1'b0, 8'hc0);
    acc(8'h01, 1'b0, 8'h32);
    step(12'h000, 12'h0cb, 1'b0, 1'b0, 1'b1, 1'b0);
    step(12'hfb0, 12'h258, 1'b0, 1'b0, 1'b1, 1'b1);
    acc(8'h00, 1'b0, 8'h00);
    acc(8'h10, 1'b0, 8'h00);
    acc(8'h01, 1'b0, 8'h7f);
    acc(8'h09, 1'b1, 8'h80);
    cmp1(alm_oe, 1'b0);
    acc(8'h09, 1'b1, 8'h00);
    step(12'h064, 12'h140, 1'b0, 1'b0, 1'b0, 1'b1);
    step(12'h064, 12'h12c, 1'b0, 1'b0, 1'b0, 1'b0);
    step(12'h144, 12'h12c, 1'b0, 1'b0, 1'b1, 1'b0);
    step(12'h140, 12'h12c, 1'b0, 1'b0, 1'b0, 1'b0);
    step(12'h140, 12'h12c, 1'b1, 1'b0, 1'b1, 1'b0);
    step(12'h140, 12'h12c, 1'b0, 1'b0, 1'b0, 1'b0);
    acc(8'h10, 1'b0, 8'h00);
    step(12'h140, 12'h0cb, 1'b0, 1'b0, 1'b0, 1'b0);
    acc(8'h01, 1'b0, 8'h4b);
    acc(8'h10, 1'b0, 8'hc0);
    acc(8'h01, 1'b0, 8'h32);
    step(12'h140, 12'h12c, 1'b0, 1'b1, 1'b0, 1'b0);
    acc(8'h01, 1'b0, 8'h32);
    step(12'h158, 12'h12c, 1'b0, 1'b0, 1'b1, 1'b1);
    acc(8'h09, 1'b1, 8'ha0);
    step(12'h144, 12'h12c, 1'b0, 1'b0, 1'b1, 1'b1);
    step(12'h118, 12'h12c, 1'b0, 1'b0, 1'b0, 1'b0);
    acc(8'h09, 1'b1, 8'h40);
    repeat (300) @(posedge mclk);
    n = rem_done;
    repeat (600) @(posedge mclk);
    cmp1(rem_done == n, 1'b1);
    acc(8'h09, 1'b1, 8'h04);
    acc(8'h30, 1'b0, 8'h50);
    acc(8'h30, 1'b1, 8'h90);
    step(12'h000, 12'hf24, 1'b0, 1'b0, 1'b0, 1'b0);
    acc(8'h00, 1'b0, 8'h40);
    acc(8'h10, 1'b0, 8'h00);
    acc(8'h01, 1'b0, 8'h09);
    acc(8'h09, 1'b1, 8'h00);
    step(12'h064, 12'h12c, 1'b0, 1'b0, 1'b0, 1'b0);
    acc(8'h01, 1'b0, 8'h4b);
    @(posedge mclk);
    dith <= 1'b1;
    acc(8'h0a, 1'b1, 8'h07);
    wait_rem(40);
    acc(8'h10, 1'b0, 8'h80);
    acc(8'h01, 1'b0, 8'h4b);
    acc(8'h0a, 1'b1, 8'h09);
    wait_rem(2);
    acc(8'h10, 1'b0, 8'h00);
    give_verdict();
  end
endmodule

// *** bench/tm_host.sv ***
// two-wire bus master model for the monitor's register port
`timescale 1ns/10ps
module tm_host #(
  parameter logic [6:0] DEV = 7'h48
) (
  output logic scl,
  output logic sda_h,
  input wire logic sda
);
  // quarter bit time: each bus clock phase spans about six mclk
  localparam realtime Q = 31.25;
  logic [7:0] rx;
  // idle: both lines released, bus clock stands high between frames
  initial begin
    scl = 1'b1;
    sda_h = 1'b1;
  end
  // ----------------------------------------------------------------
  // bit, byte and frame primitives
  // ----------------------------------------------------------------
  // data moves only while the bus clock is low
  task automatic bit_io(input logic b, output logic r);
    sda_h = b;
    #Q scl = 1'b1;
    #Q r = sda;
    #Q scl = 1'b0;
    #Q;
  endtask
  // msb first; the ninth bit is the acknowledge either way
  task automatic xfer(input logic [7:0] tx, input logic last,
                      output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(tx[i], r);
      rx[i] = r;
    end
    bit_io(last, ack);
  endtask
  task automatic start();
    sda_h = 1'b1;
    #Q scl = 1'b1;
    #Q sda_h = 1'b0;
    #Q scl = 1'b0;
    #Q;
  endtask
  task automatic stop();
    sda_h = 1'b0;
    #Q scl = 1'b1;
    #Q sda_h = 1'b1;
    #Q;
  endtask
  // pointer byte, then a data byte or a repeated start and one read
  task automatic access(input logic [7:0] a, input logic wr,
                        input logic [7:0] d, output logic [7:0] q,
                        output logic nak);
    logic k0;
    logic k1;
    logic k2;
    logic nk;
    start();
    xfer({DEV, 1'b0}, 1'b1, k0);
    xfer(a, 1'b1, k1);
    if (wr) begin
      xfer(d, 1'b1, k2);
    end else begin
      start();
      xfer({DEV, 1'b1}, 1'b1, k2);
      xfer(8'hff, 1'b1, nk);
    end
    q = rx;
    nak = k0 | k1 | k2;
    stop();
  endtask
endmodule

// *** rtl/tm_conv.sv ***
// conversion sequencer: alternation, averaging, result formatting
`timescale 1ns/10ps
`include "tm_regs.svh"
module tm_conv #(
  parameter int unsigned PERIOD_CYC = `TM_PERIOD_CYC,
  parameter int AVG_N = 16
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic standby,
  input wire logic range_ext,
  input wire logic [3:0] rate,
  input wire tm_pkg::tm_adc_s adc,
  output logic meas_req,
  output logic meas_remote,
  output logic busy,
  output tm_pkg::tm_res_s res
);
  import tm_pkg::*;
  localparam int AVG_SH = $clog2(AVG_N);
  if (AVG_N < 2 || AVG_N > 16 || (1 << AVG_SH) != AVG_N || PERIOD_CYC == 0
      || PERIOD_CYC > 32'd4000000) begin : g_bad
    $error("tm_conv: unsupported parameter");
  end
  typedef struct packed {
    tm_cv_e st;
    logic remote;
    logic [4:0] n;
    logic [15:0] acc;
    logic open;
    logic shorted;
    logic [31:0] gap;
    tm_res_s res;
  } tm_cv_st_s;
  tm_cv_st_s q, d;
  logic avg_on;
  assign avg_on = rate < `TM_AVG_FROM;

  function automatic tm_res_s fmt(input logic signed [11:0] raw,
                                  input logic ext);
    logic signed [11:0] t;
    fmt = '0;
    t = (raw >>> 2) + $signed({4'h0, ext ? `TM_EXT_OFFSET : 8'h00});
    if (t[11]) fmt.int_b = 8'h00;
    else if (t[10:8] != 3'h0 || (!ext && t[7]))
      fmt.int_b = ext ? 8'hff : 8'h7f;
    else begin
      fmt.int_b = t[7:0];
      fmt.frac_b = {raw[1:0], 6'h00};
    end
  endfunction

  always_comb begin
    logic signed [15:0] acc_n;
    logic signed [11:0] avg;
    logic [3:0] r;
    logic [4:0] n_need;
    acc_n = $signed(q.acc) + $signed({{4{adc.raw[11]}}, adc.raw});
    avg = 12'(acc_n >>> AVG_SH);
    r = (rate > `TM_RATE_MAX) ? `TM_RATE_MAX : rate;
    n_need = avg_on ? 5'(AVG_N) : 5'h01;
    d = q;
    d.res.valid = 1'b0;
    case (q.st)
      CV_IDLE: if (!standby) begin
        d.st = CV_REQ;
        d.n = 5'h00;
        d.acc = 16'h0000;
        d.open = 1'b0;
        d.shorted = 1'b0;
      end
      CV_REQ: d.st = CV_WAIT;
      CV_WAIT: if (adc.ack) begin
        d.open = q.open | adc.open;
        d.shorted = q.shorted | adc.shorted;
        if (q.n == n_need - 5'h01) begin
          // range sampled here so a switch shows in the next result
          d.res = fmt(avg_on ? avg : adc.raw, range_ext);
          d.res.valid = 1'b1;
          d.res.remote = q.remote;
          d.res.open = d.open;
          d.res.shorted = d.shorted;
          d.remote = !q.remote;
          d.st = q.remote ? CV_GAP : CV_IDLE;
          d.gap = PERIOD_CYC << (`TM_RATE_MAX - r);
        end else begin
          d.n = q.n + 5'h01;
          d.acc = acc_n;
          d.st = CV_REQ;
        end
      end
      CV_GAP: if (q.gap <= 32'h1) d.st = CV_IDLE;
              else d.gap = q.gap - 32'h1;
      default: d.st = CV_IDLE;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) q <= '0;
    else q <= d;
  end
  assign meas_req = q.st == CV_REQ;
  assign meas_remote = q.remote;
  assign busy = q.st == CV_REQ || q.st == CV_WAIT;
  assign res = q.res;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  chk_alt_channel: assert property (q.res.valid |-> q.remote != q.res.remote)
    else $error("channel did not alternate");
  chk_avg_count: assert property (q.res.valid && $past(avg_on)
    |-> $past(q.n) == 5'(AVG_N - 1))
    else $error("averaging count wrong");
  chk_no_avg: assert property (q.res.valid && !$past(avg_on)
    |-> $past(q.n) == 5'h00)
    else $error("averaging at fast rate");
  chk_ext_zero: assert property (q.st == CV_WAIT && adc.ack && !avg_on &&
    range_ext && adc.raw == 12'h000 |=> q.res.int_b == 8'h40)
    else $error("offset binary zero wrong");
  chk_bin_sat: assert property (q.res.valid && !$past(range_ext)
    |-> q.res.int_b <= 8'h7f)
    else $error("binary result not saturated");
  chk_standby_hold: assert property (standby && q.st == CV_IDLE
    |=> q.st == CV_IDLE)
    else $error("conversion started in standby");
endmodule

// *** rtl/tm_i2c.sv ***
// two-wire slave sampled on mclk, one register pointer
`timescale 1ns/10ps
module tm_i2c #(
  parameter logic [6:0] DEV_ADDR = 7'h48
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  output tm_pkg::tm_bus_s bus,
  input wire logic [7:0] rd_data
);
  import tm_pkg::*;
  typedef struct packed {
    logic [2:0] scl;
    logic [2:0] sda;
    tm_sb_e st;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic rw;
    logic first;
    logic oe;
    tm_bus_s bus;
  } tm_sb_st_s;
  tm_sb_st_s q, d;
  logic rise, fall, hi, sv, sp;
  // edges come from the second and third stages only
  assign rise = q.scl[1] && !q.scl[2];
  assign fall = !q.scl[1] && q.scl[2];
  assign hi = q.scl[1] && q.scl[2];
  assign sv = q.sda[1];
  assign sp = q.sda[2];

  always_comb begin
    d = q;
    d.bus.wr = 1'b0;
    d.bus.rd = 1'b0;
    d.scl = {q.scl[1:0], scl_i};
    d.sda = {q.sda[1:0], sda_i};
    if (hi && sp && !sv) begin
      d.st = SB_ADDR;
      d.cnt = 4'h0;
      d.oe = 1'b0;
      d.first = 1'b1;
    end else if (hi && !sp && sv) begin
      d.st = SB_IDLE;
      d.oe = 1'b0;
    end else begin
      case (q.st)
        SB_IDLE: d.oe = 1'b0;
        SB_ADDR, SB_WR: if (rise) begin
          d.sh = {q.sh[6:0], sv};
          d.cnt = q.cnt + 4'h1;
        end else if (fall && q.cnt == 4'h8) begin
          d.oe = 1'b1;
          if (q.st == SB_ADDR) begin
            d.rw = q.sh[0];
            d.st = (q.sh[7:1] == DEV_ADDR) ? SB_AACK : SB_IDLE;
            d.oe = q.sh[7:1] == DEV_ADDR;
          end else begin
            d.st = SB_WACK;
            d.first = 1'b0;
            if (q.first) d.bus.addr = q.sh;
            else begin
              d.bus.wr = 1'b1;
              d.bus.wdata = q.sh;
            end
          end
        end
        SB_AACK, SB_RACK: if (rise && q.st == SB_RACK && sv) begin
          d.st = SB_IDLE;
        end else if (fall) begin
          d.cnt = 4'h0;
          d.oe = 1'b0;
          d.st = SB_WR;
          if (q.st == SB_RACK || q.rw) begin
            d.st = SB_RD;
            d.sh = rd_data;
            d.oe = !rd_data[7];
            d.bus.rd = 1'b1;
          end
        end
        SB_WACK: if (fall) begin
          d.oe = 1'b0;
          d.cnt = 4'h0;
          d.st = SB_WR;
        end
        SB_RD: if (fall) begin
          d.cnt = q.cnt + 4'h1;
          d.sh = {q.sh[6:0], 1'b0};
          d.oe = !q.sh[6];
          if (q.cnt == 4'h7) begin
            d.oe = 1'b0;
            d.st = SB_RACK;
          end
        end
        default: d.st = SB_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      q <= '0;
      q.scl <= 3'h7;
      q.sda <= 3'h7;
    end else q <= d;
  end
  assign sda_o = 1'b0;
  assign sda_oe = q.oe;
  assign bus = q.bus;
endmodule

// *** rtl/tm_pkg.sv ***
// shared types of the temperature monitor back end
package tm_pkg;
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } tm_bus_s;
  typedef struct packed {
    logic valid;
    logic remote;
    logic [7:0] int_b;
    logic [7:0] frac_b;
    logic open;
    logic shorted;
  } tm_res_s;
  typedef struct packed {
    logic ack;
    logic signed [11:0] raw;
    logic open;
    logic shorted;
  } tm_adc_s;
  typedef enum logic [1:0] {CV_IDLE, CV_REQ, CV_WAIT, CV_GAP} tm_cv_e;
  typedef enum logic [2:0] {
    SB_IDLE, SB_ADDR, SB_AACK, SB_WR, SB_WACK, SB_RD, SB_RACK
  } tm_sb_e;
endpackage

// *** rtl/tm_regs.svh ***
// register offsets, field positions, reset values and timing counts
`ifndef TM_REGS_SVH
`define TM_REGS_SVH
`define TM_A_LOCAL 8'h00
`define TM_A_RINT 8'h01
`define TM_A_STAT 8'h02
`define TM_A_CFG_RD 8'h03
`define TM_A_RATE_RD 8'h04
`define TM_A_CFG_WR 8'h09
`define TM_A_RATE_WR 8'h0a
`define TM_A_RFRAC 8'h10
`define TM_A_HYST 8'h21
`define TM_A_LIM0 8'h30
`define TM_LIM_MASK 8'hf8
`define TM_CFG_MASK 7
`define TM_CFG_STBY 6
`define TM_CFG_PIN2 5
`define TM_CFG_EXT 2
`define TM_CFG_USED 8'he4
`define TM_RST_CFG 8'h00
`define TM_RST_RATE 8'h08
`define TM_RST_HYST 8'h0a
`define TM_RST_HIGH 8'h55
`define TM_RST_LOW 8'h00
`define TM_RST_OVERTEMP_COMPARATOR_PIN 8'h55
`define TM_EXT_OFFSET 8'h40
`define TM_AVG_FROM 4'h8
`define TM_RATE_MAX 4'ha
`define TM_PERIOD_US 15500
`define TM_CLK_MHZ 100
`define TM_PERIOD_CYC (`TM_PERIOD_US * `TM_CLK_MHZ)
`endif

// *** rtl/tm_top.sv ***
// temperature monitor back end: registers, limits, alarm pins
`timescale 1ns/10ps
`include "tm_regs.svh"
// ----------------------------------------------------------------
// ----------------------------------------------------------------
module tm_top #(
  parameter int unsigned PERIOD_CYC = `TM_PERIOD_CYC,
  parameter int AVG_N = 16,
  parameter logic [6:0] DEV_ADDR = 7'h48  // arbitrary bus address
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  output logic alarm_pin_n_o,
  output logic alarm_pin_n_oe,
  output logic overtemp_comparator_pin_n_o,
  output logic overtemp_comparator_pin_n_oe,
  output logic meas_req,
  output logic meas_remote,
  input wire tm_pkg::tm_adc_s adc
);
  import tm_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] local_v;
    logic [7:0] rint;
    logic [7:0] rfrac;
    logic [7:0] rint_hold;
    logic lock;
    logic ropen;
    logic [7:0] cfg;
    logic [7:0] rate;
    logic [7:0] hyst;
    logic [7:0][7:0] lim;
    logic [6:0] flags;
    logic upd;
    logic th_loc;
    logic th_rem;
    logic th2_loc;
    logic th2_rem;
    logic th_oe;
    logic al_oe;
  } tm_top_st_s;
  tm_top_st_s q, d;
  tm_bus_s bus;
  tm_res_s res;
  logic busy;
  logic [7:0] rd_data;
  logic [1:0] loc_cmp, rem_cmp;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [1:0] lim_cmp(input logic [9:0] v,
                                         input logic [9:0] hi,
                                         input logic [9:0] lo);
    lim_cmp = {v > hi, v <= lo};
  endfunction

  // set above the limit, clear once at or below limit minus hysteresis
  function automatic logic hyst_next(input logic act,
                                     input logic [7:0] v,
                                     input logic [7:0] lim,
                                     input logic [7:0] hy);
    if (v > lim) hyst_next = 1'b1;
    else if ({1'b0, v} + {1'b0, hy} <= {1'b0, lim}) hyst_next = 1'b0;
    else hyst_next = act;
  endfunction

  // ----------------------------------------------------------------
  // sub-blocks
  // ----------------------------------------------------------------
  tm_i2c #(
    .DEV_ADDR(DEV_ADDR)
  ) u_i2c (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .scl_i(scl_i),
    .sda_i(sda_i),
    .sda_o(sda_o),
    .sda_oe(sda_oe),
    .bus(bus),
    .rd_data(rd_data)
  );

  tm_conv #(
    .PERIOD_CYC(PERIOD_CYC),
    .AVG_N(AVG_N)
  ) u_conv (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .standby(q.cfg[`TM_CFG_STBY]),
    .range_ext(q.cfg[`TM_CFG_EXT]),
    .rate(q.rate[3:0]),
    .adc(adc),
    .meas_req(meas_req),
    .meas_remote(meas_remote),
    .busy(busy),
    .res(res)
  );

  // ----------------------------------------------------------------
  // register file and comparison
  // ----------------------------------------------------------------
  assign loc_cmp = lim_cmp({q.local_v, 2'b00}, {q.lim[0], 2'b00},
                           {q.lim[1], 2'b00});
  assign rem_cmp = lim_cmp({q.rint, q.rfrac[7:6]},
                           {q.lim[2], q.lim[4][7:6]},
                           {q.lim[3], q.lim[5][7:6]});

  always_comb begin
    d = q;
    // writes in standby still refresh flags and pins
    d.upd = res.valid | bus.wr;
    if (res.valid && !res.remote) d.local_v = res.int_b;
    if (res.valid && res.remote) begin
      d.ropen = res.open;
      if (!res.shorted) begin
        d.rint = res.int_b;
        d.rfrac = res.frac_b;
      end
    end
    // converter keeps updating rint; integer reads after a fraction read see the frozen copy
    if (bus.rd && bus.addr == `TM_A_RFRAC) begin
      d.lock = 1'b1;
      d.rint_hold = q.rint;
    end else if (bus.rd && bus.addr == `TM_A_RINT) d.lock = 1'b0;
    if (bus.wr) begin
      case (bus.addr)
        `TM_A_CFG_WR: d.cfg = bus.wdata & `TM_CFG_USED;
        `TM_A_RATE_WR: d.rate = {4'h0, bus.wdata[3:0]};
        `TM_A_HYST: d.hyst = bus.wdata;
        default: if ((bus.addr & `TM_LIM_MASK) == `TM_A_LIM0)
          d.lim[bus.addr[2:0]] = bus.wdata;
      endcase
    end
    if (q.upd) begin
      d.flags = {loc_cmp, rem_cmp, q.ropen,
                 q.rint > q.lim[6], q.local_v > q.lim[7]};
      d.th_rem = hyst_next(q.th_rem, q.rint, q.lim[6], q.hyst);
      d.th_loc = hyst_next(q.th_loc, q.local_v, q.lim[7], q.hyst);
      d.th2_rem = hyst_next(q.th2_rem, q.rint, q.lim[2], q.hyst);
      d.th2_loc = hyst_next(q.th2_loc, q.local_v, q.lim[0], q.hyst);
    end
    d.th_oe = q.th_loc | q.th_rem;
    if (q.cfg[`TM_CFG_PIN2]) d.al_oe = q.th2_loc | q.th2_rem;
    else d.al_oe = !q.cfg[`TM_CFG_MASK] && (|q.flags[6:2]);
  end

  always_comb begin
    rd_data = 8'h00;
    case (bus.addr)
      `TM_A_LOCAL: rd_data = q.local_v;
      `TM_A_RINT: rd_data = q.lock ? q.rint_hold : q.rint;
      `TM_A_STAT: rd_data = {busy, q.flags};
      `TM_A_CFG_RD: rd_data = q.cfg;
      `TM_A_RATE_RD: rd_data = q.rate;
      `TM_A_RFRAC: rd_data = q.rfrac;
      `TM_A_HYST: rd_data = q.hyst;
      default: if ((bus.addr & `TM_LIM_MASK) == `TM_A_LIM0)
        rd_data = q.lim[bus.addr[2:0]];
    endcase
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      q <= '0;
      q.cfg <= `TM_RST_CFG;
      q.rate <= `TM_RST_RATE;
      q.hyst <= `TM_RST_HYST;
      q.lim <= {`TM_RST_OVERTEMP_COMPARATOR_PIN, `TM_RST_OVERTEMP_COMPARATOR_PIN, 8'h00, 8'h00,
                `TM_RST_LOW, `TM_RST_HIGH, `TM_RST_LOW, `TM_RST_HIGH};
    end else q <= d;
  end

  // open-drain pins: enable high pulls the line low
  assign alarm_pin_n_o = 1'b0;
  assign alarm_pin_n_oe = q.al_oe;
  assign overtemp_comparator_pin_n_o = 1'b0;
  assign overtemp_comparator_pin_n_oe = q.th_oe;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  chk_local_store: assert property (res.valid && !res.remote
    |=> q.local_v == $past(res.int_b))
    else $error("local result not stored");
  chk_short_hold: assert property (res.valid && res.remote && res.shorted
    |=> $stable(q.rint) && $stable(q.rfrac))
    else $error("shorted result overwrote remote value");
  chk_frac_low: assert property (q.rfrac[5:0] == 6'h00)
    else $error("fraction low bits not zero");
  chk_lock_read: assert property (bus.rd && bus.addr == `TM_A_RINT && q.lock
    |-> rd_data == q.rint_hold)
    else $error("integer byte not frozen");
  chk_lock_freeze: assert property (q.lock && !bus.rd
    |=> q.lock && $stable(q.rint_hold))
    else $error("lock released without integer read");
  chk_high_flag: assert property (q.upd
    |=> q.flags[6] == $past(q.local_v > q.lim[0]))
    else $error("local high flag wrong");
  chk_low_flag: assert property (q.upd
    |=> q.flags[5] == $past(q.local_v <= q.lim[1]))
    else $error("local low flag wrong");
  chk_alarm_level: assert property (!q.cfg[`TM_CFG_PIN2] &&
    !q.cfg[`TM_CFG_MASK] && (|q.flags[6:3]) |=> alarm_pin_n_oe)
    else $error("alarm pin not asserted");
  chk_fault_alarm: assert property (!q.cfg[`TM_CFG_PIN2] &&
    !q.cfg[`TM_CFG_MASK] && q.flags[2] |=> alarm_pin_n_oe)
    else $error("diode fault did not raise alarm");
  chk_alarm_mask: assert property (!q.cfg[`TM_CFG_PIN2] &&
    q.cfg[`TM_CFG_MASK] |=> !alarm_pin_n_oe)
    else $error("masked alarm pin asserted");
  chk_overtemp_comparator_pin_pin: assert property (q.upd && q.local_v > q.lim[7]
    |=> ##1 overtemp_comparator_pin_n_oe)
    else $error("overtemp pin not asserted");
  chk_pin2_mode: assert property (q.cfg[`TM_CFG_PIN2]
    |=> alarm_pin_n_oe == $past(q.th2_loc | q.th2_rem))
    else $error("second overtemp output wrong");
  chk_hyst_keep: assert property (q.upd && q.th_loc &&
    ({1'b0, q.local_v} + {1'b0, q.hyst} > {1'b0, q.lim[7]})
    |=> q.th_loc)
    else $error("overtemp released inside hysteresis");
  chk_cfg_write: assert property (bus.wr && bus.addr == `TM_A_CFG_WR
    |=> q.cfg == ($past(bus.wdata) & `TM_CFG_USED))
    else $error("config write lost");
  chk_range_keep: assert property (!bus.wr |=> $stable(q.lim))
    else $error("limits changed without write");

  cov_remote_result: cover property (res.valid && res.remote);
  cov_coherent_read: cover property (bus.rd && bus.addr == `TM_A_RFRAC
    ##[1:400] bus.rd && bus.addr == `TM_A_RINT);
  cov_alarm: cover property ($rose(alarm_pin_n_oe));
  cov_overtemp_comparator_pin: cover property ($rose(overtemp_comparator_pin_n_oe));
endmodule

// *** rtl/tm_unused_none.sv ***
// spare file of the design set, holds no module
`timescale 1ns/10ps
